// >>> hdl/apsc_port.v
// audio port slot mapping, master clock generation and sample FIFO
//
// Added by the designer: strobed register access.
`include "apsc_defs.vh"

// ==================================================
// sample FIFO
// a small first-in first-out store with valid and ready on both sides
module apsc_fifo #(
  parameter WIDTH = 96,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire core_clk,
  input wire resetn,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output reg inReady,
  output wire [WIDTH-1:0] outData,
  output reg outValid,
  input wire outReady
);
  // storage is plain flip-flops, indexed by the pointers
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] count;
  wire doWr;
  wire doRd;
  wire [AW:0] next_count;
  // a transfer happens on a side only when its valid and ready are both high
  assign doWr = inValid & inReady;
  assign doRd = outValid & outReady;
  assign next_count = count + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
  assign outData = mem[rdPtr];
  // pointers and flags; flags registered so the source sees a clean ready
  // the count is one bit wider than the pointers so full and empty differ;
  // ready and valid come from the next count, so a word written here is
  // visible to the reader one edge later and never in the same cycle
  always @(posedge core_clk) begin
    if (!resetn) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      // empty after reset: ready high, nothing valid
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      if (doWr) begin
        mem[wrPtr] <= inData;
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRd)
        rdPtr <= rdPtr + 1'b1;
      count <= next_count;
      inReady <= (next_count != DEPTH[AW:0]);
      outValid <= (next_count != {(AW+1){1'b0}});
    end
  end
endmodule // apsc_fifo

// ==================================================
// port configuration and serial engine
// registers, clock plan flags, frame counter and the serial data engine;
// every output is registered so the pins never glitch between edges
module apsc_port (
  input wire core_clk,
  input wire resetn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdData,
  input wire [95:0] sampleData,
  input wire sampleValid,
  output wire sampleReady,
  input wire bclkIn,
  output reg bclkOut,
  output reg bclkOutEnN,
  input wire frameSyncIn,
  output reg frameSyncOut,
  output reg frameSyncOutEnN,
  output reg serialOut,
  output reg serialOutEnN,
  output reg autoClockActive,
  output reg pllInUse,
  output reg rateFamily44k,
  output reg [2:0] refClockFreqCode,
  output reg refClockFromFrameSync,
  output reg [2:0] refClockRatioCode
);
  // ==================================================
  // register file
  // configuration A layout: bit 7 role (1 drives the port clocks), bit 6
  // turns self clocking off, bit 5 bypasses the PLL while self clocking,
  // bit 4 gates the driven clocks, bit 3 picks the 44.1 kHz rate family,
  // bits 2:0 name the reference clock frequency
  // configuration B bits 3:0 set the bit clock to frame ratio; the source
  // register bit 6 picks how the reference clock is specified and bits 5:3
  // give its ratio to the frame sync
  reg [5:0] chan2_slot_field;
  reg [5:0] chan3_slot_field;
  reg [5:0] chan4_slot_field;
  reg [7:0] cfgA;
  reg [7:0] cfgB;
  reg [7:0] clkSrc;
  reg halfFrameFmt;
  wire port_role_select = cfgA[`APSC_ROLE_BIT];
  wire selfClockOff = cfgA[`APSC_AUTO_BIT];
  wire self_clocking_pll_off = cfgA[`APSC_PLLOFF_BIT];
  wire port_clock_gate = cfgA[`APSC_GATE_BIT];
  wire rate_family_select = cfgA[`APSC_FAMILY_BIT];
  wire ref_clock_spec_method = clkSrc[`APSC_METHOD_BIT];
  // engine state read back
  reg [10:0] bitCnt;
  reg slotActive;
  wire fifoValid;
  wire [95:0] fifoData;
  reg fifoPop;
  // frame start seen on the frame sync pin in slave role; declared here
  // because the frame geometry uses it before the divider section
  wire slaveFrameStart;

  // slot writes keep only six bits so the top two always read zero
  // software is expected to write zeros there; anything else is dropped
  // a write lands at the strobe edge and shows on a read one cycle later
  always @(posedge core_clk) begin
    if (!resetn) begin
      chan2_slot_field <= `APSC_RST_CH2;
      chan3_slot_field <= `APSC_RST_CH3;
      chan4_slot_field <= `APSC_RST_CH4;
      cfgA <= `APSC_RST_CFGA;
      cfgB <= `APSC_RST_CFGB;
      clkSrc <= `APSC_RST_CLKSRC;
      halfFrameFmt <= 1'b0;
    end else if (regWr) begin
      // unmapped offsets are ignored so stray writes do nothing
      case (regAddr)
        `APSC_OFS_CH2: chan2_slot_field <= regWrData[5:0];
        `APSC_OFS_CH3: chan3_slot_field <= regWrData[5:0];
        `APSC_OFS_CH4: chan4_slot_field <= regWrData[5:0];
        `APSC_OFS_CFGA: cfgA <= regWrData;
        `APSC_OFS_CFGB: cfgB <= regWrData;
        `APSC_OFS_CLKSRC: clkSrc <= regWrData;
        `APSC_OFS_FMT: halfFrameFmt <= regWrData[0];
        default: ;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads zero
  // status word: bit 3 sample words waiting, bit 2 current slot owned,
  // bit 1 bit clock driven, bit 0 frame counter at the first bit
  always @(posedge core_clk) begin
    if (!resetn) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `APSC_OFS_CH2: regRdData <= {2'b00, chan2_slot_field};
        `APSC_OFS_CH3: regRdData <= {2'b00, chan3_slot_field};
        `APSC_OFS_CH4: regRdData <= {2'b00, chan4_slot_field};
        `APSC_OFS_CFGA: regRdData <= cfgA;
        `APSC_OFS_CFGB: regRdData <= cfgB;
        `APSC_OFS_CLKSRC: regRdData <= clkSrc;
        `APSC_OFS_FMT: regRdData <= {7'h00, halfFrameFmt};
        `APSC_OFS_STAT: regRdData <= {4'h0, fifoValid, slotActive, ~bclkOutEnN, bitCnt == 11'h000};
        default: regRdData <= 8'h00;
      endcase
    end else begin
      // zero between reads keeps the bus quiet
      regRdData <= 8'h00;
    end
  end

  // ==================================================
  // clock plan outputs
  // the PLL choice only matters while hardware derives its own dividers
  // these are flags for the clock tree outside this block; nothing here
  // divides a clock by them, so a change shows one edge after the write
  always @(posedge core_clk) begin
    if (!resetn) begin
      autoClockActive <= 1'b0;
      pllInUse <= 1'b0;
      rateFamily44k <= 1'b0;
      refClockFreqCode <= 3'h0;
      refClockFromFrameSync <= 1'b0;
      refClockRatioCode <= 3'h0;
    end else begin
      // self clocking and PLL use follow their bits with no role condition
      autoClockActive <= ~selfClockOff;
      pllInUse <= ~selfClockOff & ~self_clocking_pll_off;
      // family and reference flags only mean anything in master role
      rateFamily44k <= port_role_select & rate_family_select;
      // fixed code only when master and method is fixed frequency
      refClockFreqCode <= (port_role_select & ~ref_clock_spec_method) ? cfgA[2:0] : 3'h0;
      refClockFromFrameSync <= port_role_select & ref_clock_spec_method;
      refClockRatioCode <= clkSrc[5:3];
    end
  end

  // ==================================================
  // frame geometry
  // bits per frame from the ratio code; reserved codes fall back to 256
  // code 8 (256 bits, the reset value) is left to the default branch;
  // codes above 12 are not for use and behave as 256 so the counter
  // always has a sane end point
  function [11:0] frameBits;
    input [3:0] code;
    begin
      case (code)
        4'h0: frameBits = 12'h010;
        4'h1: frameBits = 12'h018;
        4'h2: frameBits = 12'h020;
        4'h3: frameBits = 12'h030;
        4'h4: frameBits = 12'h040;
        4'h5: frameBits = 12'h060;
        4'h6: frameBits = 12'h080;
        4'h7: frameBits = 12'h0C0;
        4'h9: frameBits = 12'h180;
        4'hA: frameBits = 12'h200;
        4'hB: frameBits = 12'h400;
        4'hC: frameBits = 12'h800;
        default: frameBits = 12'h100;
      endcase
    end
  endfunction

  // frame length and half length follow configuration B directly
  wire [11:0] frameLen = frameBits(cfgB[3:0]);
  wire [10:0] halfLen = frameLen[11:1];
  reg [10:0] next_bitCnt;
  reg frameWrap;
  reg rightHalf;
  reg [10:0] inHalf;
  reg [5:0] slotNum;
  reg [4:0] bitInSlot;

  // slot number of the bit about to be launched; half-frame formats put
  // the right half at codes 32 and up
  // the counter runs one bit ahead here because the registers below take
  // this value at the launch edge; a frame sync in slave role forces the
  // wrap so the far side sets the frame alignment
  // in half-frame formats the left half holds only as many slots as fit
  // into half the frame, so large left codes are never reached
  always @* begin
    frameWrap = ({1'b0, bitCnt} + 12'h001 >= frameLen) | slaveFrameStart;
    next_bitCnt = frameWrap ? 11'h000 : bitCnt + 11'h001;
    rightHalf = halfFrameFmt & (next_bitCnt >= halfLen);
    inHalf = rightHalf ? next_bitCnt - halfLen : next_bitCnt;
    slotNum = halfFrameFmt ? {rightHalf, inHalf[9:5]} : next_bitCnt[10:5];
    bitInSlot = inHalf[4:0];
  end

  // ==================================================
  // bit clock: generated in master, sampled in slave
  // the divider is sized for a few core cycles a half period; with the
  // current timing the bit clock toggles on every core edge, which is the
  // fastest the core can make and sets the highest bit rate of the port
  // slave edges are taken from the pin one core cycle late, so the far
  // side's bit clock must stay in each level for at least two core cycles
  reg [3:0] divCnt;
  reg bclkPrev;
  reg fsPrev;
  wire masterRun = port_role_select & ~port_clock_gate;
  // a half period of one core cycle keeps the divider end always reached
  wire divDone = (divCnt == `APSC_BCLK_HALF_CYC - 1);
  wire masterLaunch = masterRun & divDone & bclkOut;
  wire slaveLaunch = ~port_role_select & bclkPrev & ~bclkIn;
  // a launch is the falling bit clock, in either role
  wire launch = masterLaunch | slaveLaunch;
  assign slaveFrameStart = ~port_role_select & frameSyncIn & ~fsPrev;

  // master divider; the gate holds both driven clocks low
  // the enables follow the role bit one edge late, as every other output
  always @(posedge core_clk) begin
    if (!resetn) begin
      divCnt <= 4'h0;
      bclkOut <= 1'b0;
      bclkOutEnN <= 1'b1;
      frameSyncOutEnN <= 1'b1;
      bclkPrev <= 1'b0;
      fsPrev <= 1'b0;
    end else begin
      bclkOutEnN <= ~port_role_select;
      frameSyncOutEnN <= ~port_role_select;
      // pin history for the slave edge detectors
      bclkPrev <= bclkIn;
      if (slaveLaunch)
        fsPrev <= frameSyncIn;
      if (!masterRun) begin
        divCnt <= 4'h0;
        bclkOut <= 1'b0;
      end else if (divDone) begin
        divCnt <= 4'h0;
        bclkOut <= ~bclkOut;
      end else begin
        divCnt <= divCnt + 4'h1;
      end
    end
  end

  // ==================================================
  // serial engine
  // frame being sent: channel 2 in the low word, channel 4 in the high word
  reg [95:0] frameWords;
  reg [1:0] chanHit;
  reg hit;

  // which channel owns the slot; lowest channel wins a doubled slot
  // two channels on one slot is a software fault; the fixed priority keeps
  // the pin driven by a single channel instead of a mix of both
  always @* begin
    // assume a hit and clear it when no channel matches
    hit = 1'b1;
    chanHit = 2'd0;
    if (slotNum == chan2_slot_field)
      chanHit = 2'd0;
    else if (slotNum == chan3_slot_field)
      chanHit = 2'd1;
    else if (slotNum == chan4_slot_field)
      chanHit = 2'd2;
    else
      hit = 1'b0;
  end

  // launch on the falling bit clock; a frame of samples is taken at wrap
  // a frame taken at the wrap shows from bit one of the frame it starts, since the
  // current bit zero is already on its way out; with no word waiting the
  // previous frame is sent again
  // the data pin is released in slots that no channel owns so other
  // devices can share the line
  always @(posedge core_clk) begin
    if (!resetn) begin
      bitCnt <= 11'h000;
      frameWords <= 96'h0;
      fifoPop <= 1'b0;
      slotActive <= 1'b0;
      serialOut <= 1'b0;
      serialOutEnN <= 1'b1;
      frameSyncOut <= 1'b0;
    end else begin
      fifoPop <= 1'b0;
      // gated or slave role: the frame sync output is held low
      if (port_role_select & port_clock_gate)
        frameSyncOut <= 1'b0;
      if (!port_role_select)
        frameSyncOut <= 1'b0;
      if (launch) begin
        bitCnt <= next_bitCnt;
        // frame sync goes out with bit zero and lasts one bit period
        frameSyncOut <= masterLaunch & frameWrap;
        if (frameWrap & fifoValid & ~fifoPop) begin
          frameWords <= fifoData;
          fifoPop <= 1'b1;
        end
        slotActive <= hit;
        serialOutEnN <= ~hit;
        serialOut <= hit & frameWords[chanHit * `APSC_WORD_BITS + (`APSC_WORD_BITS - 1 - bitInSlot)];
      end
    end
  end

  // four frames of buffering give software a few frames of slack between
  // refills; the pop is registered, so a word leaves one edge after its use
  apsc_fifo #(
    .WIDTH(96),
    .DEPTH(4),
    .AW(2)
  ) apsc_fifo_i (
    .core_clk(core_clk),
    .resetn(resetn),
    .inData(sampleData),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );
endmodule // apsc_port

// >>> hdl/apsc_defs.vh
// register map, field positions, reset values and timing counts for the audio port slot and master config block
`ifndef APSC_DEFS_VH
`define APSC_DEFS_VH
// ==================================================
// register offsets
`define APSC_OFS_CH2 8'h0C
`define APSC_OFS_CH3 8'h0D
`define APSC_OFS_CH4 8'h0E
`define APSC_OFS_CFGA 8'h13
`define APSC_OFS_CFGB 8'h14
`define APSC_OFS_CLKSRC 8'h16
`define APSC_OFS_FMT 8'h30
`define APSC_OFS_STAT 8'h31
// ==================================================
// reset values
`define APSC_RST_CH2 6'h01
`define APSC_RST_CH3 6'h02
`define APSC_RST_CH4 6'h03
`define APSC_RST_CFGA 8'h02
`define APSC_RST_CFGB 8'h48
`define APSC_RST_CLKSRC 8'h10
// ==================================================
// field positions
`define APSC_ROLE_BIT 7
`define APSC_AUTO_BIT 6
`define APSC_PLLOFF_BIT 5
`define APSC_GATE_BIT 4
`define APSC_FAMILY_BIT 3
`define APSC_METHOD_BIT 6
`define APSC_SLOT_W 6
// ==================================================
// timing: bit clock half period in core clock cycles, slot width in bits
`define APSC_BCLK_HALF_NS 100
`define APSC_CLK_NS 100
`define APSC_BCLK_HALF_CYC ((`APSC_BCLK_HALF_NS + `APSC_CLK_NS - 1) / `APSC_CLK_NS)
`define APSC_WORD_BITS 32
`endif

// >>> dv/apsc_port_sva.sv
// assertion checker for the audio port configuration block
module apsc_port_sva (
  input wire core_clk,
  input wire resetn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdData,
  input wire sampleReady,
  input wire bclkOut,
  input wire bclkOutEnN,
  input wire frameSyncOut,
  input wire frameSyncOutEnN,
  input wire autoClockActive,
  input wire pllInUse,
  input wire rateFamily44k,
  input wire [2:0] refClockFreqCode,
  input wire refClockFromFrameSync
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==================================================
  // shadow of the clock plan, the checker only sees the bus
  reg [7:0] cfg;
  reg [7:0] src;
  reg [15:0] p1;
  reg [15:0] p2;
  reg [1:0] ok;
  always @(posedge core_clk) begin
    if (!resetn) begin
      cfg <= 8'h02;
      src <= 8'h10;
      ok <= 2'h0;
    end else begin
      ok <= {ok[0], 1'b1};
      if (regWr && regAddr == 8'h13) cfg <= regWrData;
      if (regWr && regAddr == 8'h16) src <= regWrData;
    end
    p1 <= {cfg, src};
    p2 <= p1;
  end
  // registered flags lag a write by one edge, so judge only a settled plan
  wire st = ok[1] && {cfg, src} == p1 && p1 == p2;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_slave_released: assert property (st && !cfg[7] |-> bclkOutEnN && frameSyncOutEnN)
    else $error("slave role but a port clock is driven");
  chk_master_drives: assert property (st && cfg[7] |-> !bclkOutEnN && !frameSyncOutEnN)
    else $error("master role but a port clock is released");
  chk_bclk_toggles: assert property (st && cfg[7] && !cfg[4] |=> bclkOut != $past(bclkOut))
    else $error("master bit clock not running");
  chk_gate_quiet: assert property (st && cfg[7] && cfg[4] |-> (!bclkOut && !frameSyncOut) [*2])
    else $error("gated port clocks still move");
  chk_auto_flag: assert property (st |-> autoClockActive == !cfg[6])
    else $error("self clocking flag wrong");
  chk_pll_flag: assert property (st |-> pllInUse == (!cfg[6] && !cfg[5]))
    else $error("pll use flag wrong");
  chk_family_flag: assert property (st |-> rateFamily44k == (cfg[7] && cfg[3]))
    else $error("rate family flag wrong");
  chk_ref_code: assert property (st |-> refClockFreqCode == ((cfg[7] && !src[6]) ? cfg[2:0] : 3'h0))
    else $error("reference code wrong");
  chk_ref_method: assert property (st |-> refClockFromFrameSync == (cfg[7] && src[6]))
    else $error("reference method flag wrong");
  chk_slot_upper_zero: assert property (regRd && regAddr inside {8'h0C, 8'h0D, 8'h0E} |=> regRdData[7:6] == 2'h0)
    else $error("slot register upper bits not zero");
  cover property (st && cfg[7] && !cfg[4]);
  cover property (st && cfg[7] && cfg[4]);
  cover property (!sampleReady);
endmodule // apsc_port_sva

bind apsc_port apsc_port_sva apsc_port_sva_i (.core_clk, .resetn, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
  .sampleReady, .bclkOut, .bclkOutEnN, .frameSyncOut, .frameSyncOutEnN, .autoClockActive, .pllInUse,
  .rateFamily44k, .refClockFreqCode, .refClockFromFrameSync);

// >>> dv/apsc_host_model.sv
// host processor model: slave mode port clocks and capture of one slot
module apsc_host_model (
  input wire core_clk,
  input wire run,
  input wire [2:0] capSlot,
  input wire lineBclk,
  input wire lineFs,
  input wire lineData,
  output wire drvBclk,
  output wire drvFs,
  output reg [31:0] capWord
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==================================================
  // clock source, four core cycles a bit, still while frames are not wanted
  reg [1:0] phase = 2'h0;
  reg [7:0] bitNo = 8'h00;
  reg [7:0] rxBit = 8'h00;
  reg lastBclk = 1'b0;
  wire [7:0] nextBit = lineFs ? 8'h00 : rxBit + 8'h01;
  assign drvBclk = run & phase[1];
  assign drvFs = run & (bitNo == 8'h00);
  always @(posedge core_clk) begin
    phase <= run ? phase + 2'h1 : 2'h0;
    if (!run) bitNo <= 8'h00;
    else if (phase == 2'h3) bitNo <= bitNo + 8'h01;
  end
  // sample on each bit clock rise; frame sync marks bit zero
  always @(posedge core_clk) begin
    lastBclk <= lineBclk;
    if (lineBclk && !lastBclk) begin
      rxBit <= nextBit;
      if (nextBit[7:5] == capSlot) capWord <= {capWord[30:0], lineData};
    end
  end
endmodule // apsc_host_model

// >>> dv/apsc_port_tb_top.sv
// testbench for the audio port configuration block
module apsc_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, resetn, regWr, regRd, sampleValid, sampleReady, run;
  logic bclkOut, bclkOutEnN, frameSyncOut, frameSyncOutEnN, serialOut, serialOutEnN;
  logic autoClockActive, pllInUse, rateFamily44k, refClockFromFrameSync, drvBclk, drvFs;
  logic [7:0] regAddr, regWrData, regRdData, rdVal;
  logic [2:0] refClockFreqCode, refClockRatioCode, capSlot;
  logic [95:0] sampleData;
  logic [31:0] capWord;
  int errors = 0;
  int checks_done = 0;
  // a released data line falls to a pull-down level; released clock lines carry the host drive
  wire lineBclk = !bclkOutEnN ? bclkOut : drvBclk;
  wire lineFs = !frameSyncOutEnN ? frameSyncOut : drvFs;
  wire lineData = !serialOutEnN ? serialOut : 1'b0;
  apsc_port apsc_port_i (.core_clk, .resetn, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .sampleData, .sampleValid, .sampleReady, .bclkIn(lineBclk), .bclkOut, .bclkOutEnN,
    .frameSyncIn(lineFs), .frameSyncOut, .frameSyncOutEnN, .serialOut, .serialOutEnN,
    .autoClockActive, .pllInUse, .rateFamily44k, .refClockFreqCode, .refClockFromFrameSync,
    .refClockRatioCode);
  apsc_host_model apsc_host_model_i (.core_clk, .run, .capSlot, .lineBclk, .lineFs, .lineData,
    .drvBclk, .drvFs, .capWord);
  // ==================================================
  // bus tasks and comparison
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    // read data stand in the cycle after the strobe; take them at its closing edge
    @(posedge core_clk);
    d = regRdData;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task print_verdict;
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==================================================
  // scenarios
  task automatic t_regs;
    rd(8'h0C, rdVal); cmp(rdVal, 8'h01);
    rd(8'h0D, rdVal); cmp(rdVal, 8'h02);
    rd(8'h0E, rdVal); cmp(rdVal, 8'h03);
    rd(8'h13, rdVal); cmp(rdVal, 8'h02);
    wr(8'h0E, 8'h3F);
    rd(8'h0E, rdVal); cmp(rdVal, 8'h3F);
    wr(8'h0E, 8'h03);
    wr(8'h21, 8'h5A);
    rd(8'h21, rdVal); cmp(rdVal, 8'h00);
    wr(8'h0C, 8'h05);
    rd(8'h0C, rdVal); cmp(rdVal, 8'h05);
  endtask
  task automatic t_plan;
    logic [7:0] a, s;
    for (int k = 0; k < 16; k++) begin
      a = (k < 8) ? {5'h10, k[2:0]} : {k[0], k[1], k[2], 2'h1, 3'h5};
      s = {1'b0, k >= 8 && k[1], k[2:0] ^ 3'h2, 3'h0};
      wr(8'h13, a);
      wr(8'h16, s);
      wait_cyc(4);
      cmp({autoClockActive, pllInUse, rateFamily44k, refClockFreqCode, refClockFromFrameSync, refClockRatioCode},
        {!a[6], !a[6] && !a[5], a[7] && a[3], (a[7] && !s[6]) ? a[2:0] : 3'h0,
        a[7] && s[6], s[5:3]});
    end
    wr(8'h13, 8'h02);
    wr(8'h16, 8'h10);
  endtask
  task automatic t_fill;
    sampleValid <= 1'b1;
    wait_cyc(12);
    cmp(sampleReady, 1'b0);
  endtask
  task automatic t_slave;
    run <= 1'b1;
    wait_cyc(4500);
    cmp(capWord, sampleData[31:0]);
    capSlot <= 3'h2;
    wait_cyc(1100);
    cmp(capWord, sampleData[63:32]);
  endtask
  task automatic t_master;
    run <= 1'b0;
    capSlot <= 3'h5;
    wr(8'h13, 8'h82);
    wait_cyc(2200);
    cmp(capWord, sampleData[31:0]);
    wr(8'h30, 8'h01);
    wr(8'h0E, 8'h20);
    capSlot <= 3'h4;
    wait_cyc(1100);
    cmp(capWord, sampleData[95:64]);
    wr(8'h13, 8'h92);
    wait_cyc(5);
    cmp({bclkOut, frameSyncOut}, 2'h0);
  endtask
  task automatic t_drain;
    sampleValid <= 1'b0;
    wr(8'h13, 8'h82);
    wait_cyc(3600);
    rd(8'h31, rdVal);
    cmp(rdVal[3], 1'b0);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // hang guard, about three times the planned run
  initial begin
    wait_cyc(40000);
    errors++;
    print_verdict;
  end
  initial begin
    resetn = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    sampleValid = 1'b0;
    sampleData = {32'h3C5A96E1, 32'h0FF0A55A, 32'hC3A55A3C};
    run = 1'b0;
    capSlot = 3'h5;
    wait_cyc(16);
    resetn <= 1'b1;
    t_regs;
    t_plan;
    t_fill;
    t_slave;
    t_master;
    t_drain;
    print_verdict;
  end
endmodule // apsc_port_tb_top
